// ===== common/nv_store_regs.svh
`ifndef NV_STORE_REGS_SVH
`define NV_STORE_REGS_SVH

// array geometry
`define NV_WORDS 32
`define NV_DATA_W 14
`define NV_ADDR_W 5
`define NV_PAGE_WORDS 16
`define NV_DATA_LO_W 8

// register byte offsets
`define NV_OFF_ADDR 12'h000
`define NV_OFF_DATA_LO 12'h004
`define NV_OFF_DATA_HI 12'h008
`define NV_OFF_CTRL 12'h00c

// control field positions
`define NV_CTRL_TSEL_LSB 6
`define NV_CTRL_ERASE_EN 5
`define NV_CTRL_ERASE_TRIG 4
`define NV_CTRL_WRITE_EN 3
`define NV_CTRL_WRITE_TRIG 2
`define NV_CTRL_READ_EN 1
`define NV_CTRL_READ_TRIG 0

// reset values
`define NV_RST_ADDR 5'h00
`define NV_RST_DATA 14'h0000
`define NV_RST_CTRL 8'h00

// timing
`define NV_CLK_PERIOD_NS 10
`define NV_PROG_BASE_MS 2
`define NV_PROG_BASE_CYCLES ((`NV_PROG_BASE_MS * 1000000) / `NV_CLK_PERIOD_NS)
`define NV_READ_CYCLES 2

`endif

// ===== common/nv_store_pkg.sv
`include "nv_store_regs.svh"

package nv_store_pkg;

    // operation sequencer states, gray along idle -> erase or read -> idle; write (2'b11) is two bits from idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b11,
        ST_READ = 2'b10
    } nv_state_e;

    // control register layout, msb first
    typedef struct packed {
        logic [1:0] program_time_select;
        logic erase_enable;
        logic erase_trigger;
        logic write_enable_bit;
        logic write_trigger;
        logic read_enable_bit;
        logic read_trigger;
    } nv_ctrl_s;

    // command into the word array
    typedef struct packed {
        logic erase;
        logic write;
        logic [`NV_ADDR_W-1:0] addr;
        logic [`NV_DATA_W-1:0] wdata;
    } mem_cmd_s;

endpackage

// ===== hdl/nv_word_array.sv
`timescale 1ns/1ns
`include "nv_store_regs.svh"

module nv_word_array
    import nv_store_pkg::*;
#(
    parameter int WORDS = `NV_WORDS,
    parameter int DATA_W = `NV_DATA_W,
    parameter int ADDR_W = `NV_ADDR_W,
    parameter int PAGE_WORDS = `NV_PAGE_WORDS
) (
    // clock
    input wire logic pclk,
    // command and read word
    input wire mem_cmd_s cmd,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem_r [WORDS];

    ////////////////////////////////////////////////////////////////////////////
    // storage words; no reset since contents are meant to survive resets
    genvar g;
    generate
        for (g = 0; g < WORDS; g = g + 1) begin : g_word
            localparam logic PAGE_ID = 1'(g / PAGE_WORDS);
            localparam logic [ADDR_W-1:0] WADDR = ADDR_W'(g);
            wire erase_hit = cmd.erase && (cmd.addr[ADDR_W-1] == PAGE_ID);
            wire write_hit = cmd.write && (cmd.addr == WADDR);
            always_ff @(posedge pclk) begin
                if (erase_hit) begin
                    mem_r[g] <= '0;
                end else if (write_hit) begin
                    mem_r[g] <= cmd.wdata;
                end
            end
        end
    endgenerate

    // one-word read by index
    assign rdata = mem_r[cmd.addr];

endmodule // nv_word_array

// ===== hdl/nv_store_ctrl.sv
`timescale 1ns/1ns
`include "nv_store_regs.svh"

module nv_store_ctrl
    import nv_store_pkg::*;
#(
    parameter int PADDR_W = 12,
    parameter int CNT_W = 24,
    parameter int PROG_BASE_CYCLES = `NV_PROG_BASE_CYCLES,
    parameter int READ_CYCLES = `NV_READ_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor hold while an operation runs
    output logic cpu_stall
);

    localparam int AW = `NV_ADDR_W;
    localparam int DW = `NV_DATA_W;
    localparam int LW = `NV_DATA_LO_W;
    localparam int HW = DW - LW;

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [DW-1:0] data_r;
    logic [DW-1:0] data_nxt;
    nv_ctrl_s ctrl_r;
    nv_ctrl_s ctrl_nxt;
    nv_state_e state_r;
    nv_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic arm_erase_r;
    logic arm_erase_nxt;
    logic arm_write_r;
    logic arm_write_nxt;
    logic fin_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire idle = (state_r == ST_IDLE);
    wire hit_addr = (paddr == `NV_OFF_ADDR);
    wire hit_lo = (paddr == `NV_OFF_DATA_LO);
    wire hit_hi = (paddr == `NV_OFF_DATA_HI);
    wire hit_ctrl = (paddr == `NV_OFF_CTRL);
    wire mapped = hit_addr | hit_lo | hit_hi | hit_ctrl;
    // low byte lane carries every register
    wire lane0 = pstrb[0];
    wire xfer = psel & penable & pready;
    wire wr_ok = xfer & pwrite & mapped & lane0;
    wire wr_addr = wr_ok & hit_addr;
    wire wr_lo = wr_ok & hit_lo;
    wire wr_hi = wr_ok & hit_hi;
    wire wr_ctrl = wr_ok & hit_ctrl;

    // the access stalls during an operation and for one cycle after it,
    // so that read data captured after the finish is what the bus returns
    assign pready = idle & ~fin_r;
    assign pslverr = psel & penable & ~mapped;
    assign cpu_stall = ~idle;

    ////////////////////////////////////////////////////////////////////////////
    // control write decode

    nv_ctrl_s wctrl;
    assign wctrl = nv_ctrl_s'(pwdata[7:0]);

    // erase needs the enable already set and set by the transfer just before
    wire go_erase = wr_ctrl & wctrl.erase_trigger & wctrl.erase_enable
                    & ctrl_r.erase_enable & arm_erase_r;
    wire go_write = wr_ctrl & wctrl.write_trigger & wctrl.write_enable_bit
                    & ctrl_r.write_enable_bit & arm_write_r;
    // reads only need the enable set by an earlier transfer
    wire go_read = wr_ctrl & wctrl.read_trigger & wctrl.read_enable_bit
                   & ctrl_r.read_enable_bit;

    // one operation at a time; erase outranks write outranks read
    wire start_erase = go_erase;
    wire start_write = go_write & ~go_erase;
    wire start_read = go_read & ~go_erase & ~go_write;

    ////////////////////////////////////////////////////////////////////////////
    // program duration

    // base time doubles per select step: 2, 4, 8, 16 ms
    wire [CNT_W-1:0] prog_base = CNT_W'(PROG_BASE_CYCLES);
    wire [CNT_W-1:0] prog_len = prog_base << wctrl.program_time_select;
    wire [CNT_W-1:0] read_len = CNT_W'(READ_CYCLES);
    wire cnt_done = (cnt_r == '0);
    wire finish = ~idle & cnt_done;

    ////////////////////////////////////////////////////////////////////////////
    // word array

    mem_cmd_s mem_cmd;
    logic [DW-1:0] mem_rdata;

    // commit happens on the last cycle of the timed operation
    assign mem_cmd.erase = finish & (state_r == ST_ERASE);
    assign mem_cmd.write = finish & (state_r == ST_WRITE);
    assign mem_cmd.addr = addr_r;
    assign mem_cmd.wdata = data_r;

    nv_word_array #(
        .WORDS(`NV_WORDS),
        .DATA_W(DW),
        .ADDR_W(AW),
        .PAGE_WORDS(`NV_PAGE_WORDS)
    ) u_array (
        .pclk(pclk),
        .cmd(mem_cmd),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer next state

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (start_erase) begin
                    state_nxt = ST_ERASE;
                    cnt_nxt = prog_len - 1'b1;
                end else if (start_write) begin
                    state_nxt = ST_WRITE;
                    cnt_nxt = prog_len - 1'b1;
                end else if (start_read) begin
                    state_nxt = ST_READ;
                    cnt_nxt = read_len - 1'b1;
                end
            end
            ST_ERASE, ST_WRITE, ST_READ: begin
                if (cnt_done) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // arming: remember whether the last completed transfer set an enable without its trigger

    always_comb begin
        arm_erase_nxt = arm_erase_r;
        arm_write_nxt = arm_write_r;
        if (xfer) begin
            // any transfer in between breaks the back-to-back pair
            arm_erase_nxt = wr_ctrl & wctrl.erase_enable & ~wctrl.erase_trigger;
            arm_write_nxt = wr_ctrl & wctrl.write_enable_bit & ~wctrl.write_trigger;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register next value

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = wctrl;
            // a trigger only sticks when its operation really starts
            ctrl_nxt.erase_trigger = start_erase;
            ctrl_nxt.write_trigger = start_write;
            ctrl_nxt.read_trigger = start_read;
        end
        if (finish) begin
            case (state_r)
                ST_ERASE: begin
                    ctrl_nxt.erase_trigger = 1'b0;
                    ctrl_nxt.erase_enable = 1'b0;
                end
                ST_WRITE: begin
                    ctrl_nxt.write_trigger = 1'b0;
                    ctrl_nxt.write_enable_bit = 1'b0;
                end
                ST_READ: begin
                    // read enable deliberately left set
                    ctrl_nxt.read_trigger = 1'b0;
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and data registers next value

    always_comb begin
        addr_nxt = addr_r;
        data_nxt = data_r;
        if (wr_addr) begin
            addr_nxt = pwdata[AW-1:0];
        end
        if (wr_lo) begin
            data_nxt[LW-1:0] = pwdata[LW-1:0];
        end
        if (wr_hi) begin
            data_nxt[DW-1:LW] = pwdata[HW-1:0];
        end
        if (finish && (state_r == ST_READ)) begin
            data_nxt = mem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unused upper bits read as zero

    wire [31:0] rd_addr = {{(32-AW){1'b0}}, addr_r};
    wire [31:0] rd_lo = {{(32-LW){1'b0}}, data_r[LW-1:0]};
    wire [31:0] rd_hi = {{(32-HW){1'b0}}, data_r[DW-1:LW]};
    wire [31:0] rd_ctrl = {24'h000000, ctrl_r};

    always_comb begin
        prdata_nxt = 32'h00000000;
        if (hit_addr) begin
            prdata_nxt = rd_addr;
        end else if (hit_lo) begin
            prdata_nxt = rd_lo;
        end else if (hit_hi) begin
            prdata_nxt = rd_hi;
        end else if (hit_ctrl) begin
            prdata_nxt = rd_ctrl;
        end
    end

    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= `NV_RST_ADDR;
            data_r <= `NV_RST_DATA;
            ctrl_r <= nv_ctrl_s'(`NV_RST_CTRL);
        end else begin
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            fin_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            fin_r <= finish;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_erase_r <= 1'b0;
            arm_write_r <= 1'b0;
        end else begin
            arm_erase_r <= arm_erase_nxt;
            arm_write_r <= arm_write_nxt;
        end
    end

    // read data sampled every cycle; the access phase sees the value
    // settled one edge earlier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

endmodule // nv_store_ctrl

// ===== bench/nv_store_monitor.sv
`timescale 1ns/1ns
module nv_store_monitor #(
    parameter int PADDR_W = 12,
    parameter int PROG_BASE_CYCLES = 8,
    parameter int READ_CYCLES = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // stall
    input wire logic cpu_stall
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // access decode
    wire acc = psel && penable;
    wire taken = acc && pready;
    wire ctrl_wr = taken && pwrite && paddr == 12'h00c && pstrb[0];
    logic [31:0] cnt_r;
    logic [7:0] cmd_r;
    // stall length and the last control word, kept to judge each run's duration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0;
            cmd_r <= 8'h00;
        end else begin
            cnt_r <= cpu_stall ? cnt_r + 32'h1 : 32'h0;
            if (ctrl_wr) cmd_r <= pwdata[7:0];
        end
    end
    // bus must come back one cycle late, then be ready
    sequence resume_step;
        !pready ##1 pready;
    endsequence
    ////////////////////////////////////////
    chk_stall_holds_bus: assert property (cpu_stall |-> !pready)
        else $error("bus answered during an operation");
    chk_start_from_ctrl: assert property ($rose(cpu_stall) |-> $past(ctrl_wr))
        else $error("operation began without a control write");
    chk_prog_length: assert property ($fell(cpu_stall) && cmd_r[5:2] != 4'h0
        |-> cnt_r == (PROG_BASE_CYCLES << cmd_r[7:6])) else $error("program time wrong");
    chk_read_length: assert property ($fell(cpu_stall) && cmd_r[5:2] == 4'h0
        |-> cnt_r == READ_CYCLES) else $error("read time wrong");
    chk_resume_after_op: assert property ($fell(cpu_stall) |-> resume_step)
        else $error("bus not resumed after operation");
    chk_addr_readback: assert property (acc && !pwrite && paddr == 12'h000
        |-> prdata[31:5] == 27'h0) else $error("address upper bits set");
    chk_hi_readback: assert property (acc && !pwrite && paddr == 12'h008
        |-> prdata[31:6] == 26'h0) else $error("data high upper bits set");
    chk_trig_self_clear: assert property (taken && !pwrite && paddr == 12'h00c
        |-> (prdata & 32'hffffff15) == 32'h0) else $error("trigger still set");
    chk_unmapped_err: assert property (acc
        |-> pslverr == (paddr[1:0] != 2'b0 || paddr > 12'h00c)) else $error("error flag wrong");
endmodule // nv_store_monitor

bind nv_store_ctrl nv_store_monitor #(.PADDR_W(PADDR_W), .PROG_BASE_CYCLES(PROG_BASE_CYCLES),
    .READ_CYCLES(READ_CYCLES)) i_nv_store_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall));

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int PB = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_stall, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    int n_mismatch, n_tests, n;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_s;
    // plain register cases: write, then read back what should stick
    row_s rows [8] = '{'{12'h000, 32'hff, 32'h1f, 1'b0}, '{12'h004, 32'h1a5, 32'ha5, 1'b0},
        '{12'h008, 32'hff, 32'h3f, 1'b0}, '{12'h010, 32'h55, 32'h0, 1'b1},
        '{12'h00c, 32'hc3, 32'hc2, 1'b0}, '{12'h00c, 32'h0c, 32'h08, 1'b0},
        '{12'h00c, 32'h30, 32'h20, 1'b0}, '{12'h00c, 32'h00, 32'h00, 1'b0}};

    nv_store_ctrl #(.PROG_BASE_CYCLES(PB), .READ_CYCLES(2)) i_nv_store_ctrl (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_stall(cpu_stall));

    // 100 MHz keeps the system clock far above the minimum for programming
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // one apb transfer; pready, prdata and pslverr are sampled at the rising edge that
    // ends it, and the request is released by non-blocking assignment on that edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    // enable then trigger back to back, then time the stall; no interrupts exist here,
    // and the bench never sleeps or starts anything before the stall ends
    task automatic op(input logic [7:0] en, input logic [7:0] tg, input int exp_n);
        xfer(1'b1, 12'h00c, {24'h0, en});
        xfer(1'b1, 12'h00c, {24'h0, tg});
        n = 0;
        while (cpu_stall === 1'b1 && n < 5000) begin
            n++;
            @(posedge pclk);
            #1;
        end
        chk(n, exp_n);
    endtask
    task automatic wr_word(input logic [4:0] a, input logic [13:0] v);
        xfer(1'b1, 12'h000, {27'h0, a});
        xfer(1'b1, 12'h004, {24'h0, v[7:0]});
        xfer(1'b1, 12'h008, {26'h0, v[13:8]});
        op(8'h08, 8'h0c, PB);
    endtask
    // data pair cleared first so a stale value cannot pass
    task automatic rd_word(input logic [4:0] a, input logic [13:0] v);
        xfer(1'b1, 12'h000, {27'h0, a});
        xfer(1'b1, 12'h004, 32'h0);
        xfer(1'b1, 12'h008, 32'h0);
        op(8'h02, 8'h03, 2);
        xfer(1'b0, 12'h004, 32'h0);
        chk(r, {24'h0, v[7:0]});
        xfer(1'b0, 12'h008, 32'h0);
        chk(r, {26'h0, v[13:8]});
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        n_mismatch = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 12'(i * 4), 32'h0);
            chk(r, 32'h0);
        end
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d);
            chk(cpu_stall, 32'h0);
            xfer(1'b0, rows[i].a, 32'h0);
            chk(r, rows[i].q);
            chk(e, rows[i].e);
        end
        // a write with its low strobe off must leave the register alone
        @(posedge pclk);
        pstrb <= 4'h0;
        xfer(1'b1, 12'h000, 32'h0a);
        pstrb <= 4'hf;
        xfer(1'b0, 12'h000, 32'h0);
        chk(r, 32'h1f);
        // every time select, alternating pages, junk in the low address bits;
        // both pages end up erased before any word is written
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, 12'h000, {27'h0, s[0], 4'hf});
            op({s[1:0], 6'h20}, {s[1:0], 6'h30}, PB << s);
            xfer(1'b0, 12'h00c, 32'h0);
            chk(r, {24'h0, s[1:0], 6'h00});
        end
        wr_word(5'd3, 14'h2abc);
        wr_word(5'd19, 14'h1234);
        rd_word(5'd3, 14'h2abc);
        rd_word(5'd19, 14'h1234);
        xfer(1'b0, 12'h00c, 32'h0);
        chk(r, 32'h02);
        // erase page one only; page zero keeps its word
        xfer(1'b1, 12'h000, 32'h10);
        op(8'h20, 8'h30, PB);
        rd_word(5'd19, 14'h0);
        rd_word(5'd3, 14'h2abc);
        // a transfer between enable and trigger disarms the write
        xfer(1'b1, 12'h00c, 32'h08);
        xfer(1'b0, 12'h000, 32'h0);
        xfer(1'b1, 12'h00c, 32'h0c);
        chk(cpu_stall, 32'h0);
        xfer(1'b0, 12'h00c, 32'h0);
        chk(r, 32'h08);
        wrap_up();
    end
endmodule // tb_top
